// ==== bench/osc_select_divider_properties.sv ====
// concurrent checks on the register port and clock enables
`timescale 1ns/1ps
`default_nettype none

module osc_select_divider_properties
    import osc_ctrl_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [1:0]  regAddr,
    input wire logic        regRead,
    input wire logic [15:0] regRdData,
    input wire logic [2:0]  currentSource,
    input wire logic [2:0]  targetSource,
    input wire logic        secOscOn,
    input wire logic [5:0]  fastRcTrim,
    input wire logic        periphClkEn,
    input wire logic        cpuClkEn,
    input wire logic        sysClkOpen
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    wire oscRd = regRead && regAddr == ADDR_OSC;

    rdata_idle_a: assert property (
        !regRead |=> regRdData == 16'h0) else $error("stray read data");
    unmapped_zero_a: assert property (
        regRead && regAddr == 2'h3 |=> regRdData == 16'h0)
        else $error("unmapped index read not zero");
    cur_field_a: assert property (
        oscRd |=> regRdData[14:12] == $past(currentSource))
        else $error("current source field wrong");
    tgt_field_a: assert property (
        oscRd |=> regRdData[10:8] == $past(targetSource))
        else $error("requested source field wrong");
    sec_bit_a: assert property (
        oscRd |=> regRdData[1] == $past(secOscOn))
        else $error("secondary enable bit wrong");
    trim_field_a: assert property (
        regRead && regAddr == ADDR_TRIM |=>
        regRdData == {10'h0, $past(fastRcTrim)})
        else $error("trim read wrong");
    gate_short_a: assert property (
        !sysClkOpen |=> sysClkOpen) else $error("clock gate closed too long");
    change_copy_a: assert property (
        !sysClkOpen |-> ##[0:1] currentSource == targetSource)
        else $error("changeover did not copy source");
    cpu_in_periph_a: assert property (
        cpuClkEn |-> periphClkEn)
        else $error("cpu pulse off peripheral pulse");
    no_postscale_a: assert property (
        (currentSource < 3'h6 && sysClkOpen) [*3] |-> periphClkEn)
        else $error("postscaler active on undivided source");

    cover property (!sysClkOpen);
    cover property (cpuClkEn ##1 !cpuClkEn);
    cover property (oscRd ##1 regRdData[3]);
endmodule : osc_select_divider_properties

bind osc_select_divider osc_select_divider_properties i_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regRead(regRead), .regRdData(regRdData),
    .currentSource(currentSource), .targetSource(targetSource),
    .secOscOn(secOscOn), .fastRcTrim(fastRcTrim),
    .periphClkEn(periphClkEn), .cpuClkEn(cpuClkEn),
    .sysClkOpen(sysClkOpen)
);

`default_nettype wire

// ==== bench/osc_select_divider_test.sv ====
// self-checking bench of the oscillator select and divider block
`timescale 1ns/1ps
`default_nettype none

module osc_select_divider_test
    import osc_ctrl_pkg::*;
;
    logic        ref_clk    = 1'b0;
    logic        rst_n      = 1'b0;
    osc_cfg_t    cfg        = '{2'h3, 3'h7, 1'b0, 1'b0};
    osc_evt_t    evt        = osc_evt_t'(5'b11000);
    logic [1:0]  regAddr    = '0;
    logic [1:0]  regByteEn  = '0;
    logic [15:0] regWrData  = '0;
    logic        regWrite   = 1'b0;
    logic        regRead    = 1'b0;
    logic [15:0] regRdData;
    logic [2:0]  currentSource;
    logic [1:0]  primarySubmode;
    logic        pllEnable;
    logic        periphClkEn;
    logic        cpuClkEn;
    int          fails      = 0;
    int          checkCount = 0;
    int          cycles     = 0;
    int          nPer;
    int          nCpu;
    int          sh [8]     = '{0, 1, 2, 3, 4, 5, 6, 8};

    always #2.5 ref_clk = ~ref_clk;

    osc_select_divider i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .cfg(cfg), .evt(evt),
        .regAddr(regAddr), .regByteEn(regByteEn), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .currentSource(currentSource), .targetSource(),
        .primarySubmode(primarySubmode), .pllEnable(pllEnable),
        .secOscOn(), .fastRcTrim(), .periphClkEn(periphClkEn),
        .cpuClkEn(cpuClkEn), .sysClkOpen()
    );

    task automatic giveVerdict;
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : giveVerdict

    task automatic cmpData(string name, logic [15:0] exp, logic [15:0] got);
        checkCount++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmpData

    task automatic cmpCount(string name, int exp, int got);
        checkCount++;
        if (got != exp)
        begin
            fails++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask : cmpCount

    task automatic wr(logic [1:0] a, logic [1:0] be, logic [15:0] d);
        @(posedge ref_clk);
        regWrite  <= 1'b1;
        regRead   <= 1'b0;
        regAddr   <= a;
        regByteEn <= be;
        regWrData <= d;
    endtask : wr

    task automatic idle;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        regRead  <= 1'b0;
    endtask : idle

    task automatic rd(logic [1:0] a, logic [15:0] exp, string name);
        @(posedge ref_clk);
        regRead  <= 1'b1;
        regWrite <= 1'b0;
        regAddr  <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 cmpData(name, exp, regRdData);
    endtask : rd

    // key pair and payload go out as three back-to-back writes on one lane
    task automatic kw(bit hi, logic [7:0] d);
        logic [1:0] be;
        logic [7:0] k1;
        logic [7:0] k2;
        be = hi ? 2'b10 : 2'b01;
        k1 = hi ? KEY_HI1 : KEY_LO1;
        k2 = hi ? KEY_HI2 : KEY_LO2;
        wr(ADDR_OSC, be, {k1, k1});
        wr(ADDR_OSC, be, {k2, k2});
        wr(ADDR_OSC, be, {d, d});
        idle();
    endtask : kw

    task automatic evtPulse(osc_evt_t m, int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            evt <= evt | m;
            @(posedge ref_clk);
            evt <= evt & ~m;
        end
    endtask : evtPulse

    // reset in mid-run with new straps; event inputs back to idle levels
    task automatic restart(osc_cfg_t c);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        cfg   <= c;
        evt   <= osc_evt_t'(5'b11000);
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : restart

    // settle past any old divider phase, then count over a whole window
    task automatic count;
        nPer = 0;
        nCpu = 0;
        repeat (260) @(posedge ref_clk);
        repeat (512)
        begin
            @(posedge ref_clk);
            #1;
            nPer += int'(periphClkEn);
            nCpu += int'(cpuClkEn);
        end
    endtask : count

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fails++;
            giveVerdict();
        end
    end

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(ADDR_OSC, 16'h7700, "osc reset");
        rd(ADDR_DIV, 16'h3100, "div reset");
        rd(ADDR_TRIM, 16'h0000, "trim reset");
        wr(2'h3, 2'b11, 16'hffff);
        rd(2'h3, 16'h0000, "unmapped");
        wr(ADDR_TRIM, 2'b11, 16'hffe0);
        rd(ADDR_TRIM, 16'h0020, "trim");
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_DIV, 2'b11, {5'h0, i[2:0], 8'h0});
            idle();
            count();
            cmpCount("periph pulses", 512 >> sh[i], nPer);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_DIV, 2'b11, {1'b0, i[2:0], 1'b1, 11'h0});
            idle();
            count();
            cmpCount("cpu pulses", 512 >> i, nCpu);
        end
        wr(ADDR_DIV, 2'b11, 16'h7000);
        idle();
        count();
        cmpCount("cpu undivided", 512, nCpu);
        wr(ADDR_DIV, 2'b11, 16'h3800);
        idle();
        evtPulse(osc_evt_t'(5'b00001), 1);
        rd(ADDR_DIV, 16'h3800, "irq no recover");
        wr(ADDR_DIV, 2'b11, 16'hb800);
        idle();
        evtPulse(osc_evt_t'(5'b00001), 1);
        rd(ADDR_DIV, 16'hb000, "irq recover");
        wr(ADDR_OSC, 2'b10, 16'h0500);
        idle();
        rd(ADDR_OSC, 16'h7700, "unkeyed write");
        kw(1'b1, 8'h05);
        rd(ADDR_OSC, 16'h7500, "target");
        kw(1'b0, 8'h03);
        repeat (4) @(posedge ref_clk);
        evtPulse(osc_evt_t'(5'b00100), 9);
        repeat (4) @(posedge ref_clk);
        #1 cmpData("early source", 16'h0007, {13'h0, currentSource});
        evtPulse(osc_evt_t'(5'b00100), 1);
        repeat (4) @(posedge ref_clk);
        rd(ADDR_OSC, 16'h5502, "switched");
        kw(1'b0, 8'h03);
        repeat (4) @(posedge ref_clk);
        rd(ADDR_OSC, 16'h5502, "redundant");
        evtPulse(osc_evt_t'(5'b00010), 1);
        rd(ADDR_OSC, 16'h550a, "fail set");
        kw(1'b0, 8'h02);
        rd(ADDR_OSC, 16'h5502, "fail clear");
        kw(1'b0, 8'h0a);
        rd(ADDR_OSC, 16'h5502, "fail soft set");
        kw(1'b1, 8'h01);
        kw(1'b0, 8'h03);
        repeat (4) @(posedge ref_clk);
        evtPulse(osc_evt_t'(5'b00100), 10);
        repeat (4) @(posedge ref_clk);
        rd(ADDR_OSC, 16'h1122, "pll source");
        cmpData("pll enable", 16'h0001, {15'h0, pllEnable});
        kw(1'b0, 8'h82);
        rd(ADDR_OSC, 16'h11a2, "lock set");
        kw(1'b1, 8'h02);
        rd(ADDR_OSC, 16'h11a2, "locked target");
        @(posedge ref_clk);
        evt.pllLocked <= 1'b0;
        rd(ADDR_OSC, 16'h1182, "pll unlocked");
        restart('{2'h3, 3'h6, 1'b0, 1'b0});
        rd(ADDR_OSC, 16'h6600, "lpfrc start");
        count();
        cmpCount("lpfrc pulses", 256, nPer);
        restart('{2'h2, 3'h3, 1'b0, 1'b0});
        rd(ADDR_OSC, 16'h3320, "pll start");
        cmpData("submode", 16'h0002, {14'h0, primarySubmode});
        restart('{2'h3, 3'h2, 1'b1, 1'b1});
        rd(ADDR_OSC, 16'h7700, "fallback start");
        kw(1'b0, 8'h80);
        rd(ADDR_OSC, 16'h7700, "no lock");
        giveVerdict();
    end
endmodule : osc_select_divider_test

`default_nettype wire

// ==== src/osc_ctrl_pkg.sv ====
// shared constants and types of the oscillator select and divider block
package osc_ctrl_pkg;

    localparam logic [1:0] ADDR_OSC  = 2'h0;
    localparam logic [1:0] ADDR_DIV  = 2'h1;
    localparam logic [1:0] ADDR_TRIM = 2'h2;

    localparam int CUR_LSB     = 12;
    localparam int NEXT_LSB    = 8;
    localparam int LOCKSEL_BIT = 7;
    localparam int PLLLOCK_BIT = 5;
    localparam int FAIL_BIT    = 3;
    localparam int SEC_BIT     = 1;
    localparam int REQ_BIT     = 0;
    localparam int ROI_BIT     = 15;
    localparam int RATIO_LSB   = 12;
    localparam int SLOW_BIT    = 11;
    localparam int POST_LSB    = 8;
    localparam int TRIM_LSB    = 0;
    localparam int HI_LSB      = 8;
    localparam int LO_LSB      = 0;
    localparam int HI_LANE     = 1;
    localparam int LO_LANE     = 0;

    localparam logic [2:0] RATIO_RST = 3'h3;
    localparam logic [2:0] POST_RST  = 3'h1;
    localparam logic [2:0] POST_MAX  = 3'h7;
    localparam logic [7:0] LIM_MAX   = 8'hff;

    localparam logic [7:0] KEY_HI1 = 8'h78;
    localparam logic [7:0] KEY_HI2 = 8'h9a;
    localparam logic [7:0] KEY_LO1 = 8'h46;
    localparam logic [7:0] KEY_LO2 = 8'h57;

    localparam logic [3:0] SETTLE_TICKS = 4'ha;

    typedef enum logic [2:0] {
        SRC_FRC    = 3'h0,
        SRC_FAST_RC_WITH_PLL = 3'h1,
        SRC_PRI    = 3'h2,
        SRC_PRIPLL = 3'h3,
        SRC_SEC    = 3'h4,
        SRC_LOW_POWER_RC_OSC   = 3'h5,
        SRC_LPFRCD = 3'h6,
        SRC_FAST_RC_DIVIDED = 3'h7
    } src_t;

    localparam logic [1:0] SUB_EC_SEC   = 2'h0;
    localparam logic [1:0] SUB_INTERNAL = 2'h3;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'h0,
        PH_CHECK  = 3'h1,
        PH_WAIT   = 3'h2,
        PH_SETTLE = 3'h3,
        PH_CHANGE = 3'h4
    } phase_t;

    typedef enum logic [1:0] {
        KEY_IDLE  = 2'h0,
        KEY_FIRST = 2'h1,
        KEY_ARMED = 2'h2
    } key_t;

    typedef struct packed {
        logic [1:0] primarySubmodeCfg;
        logic [2:0] initialSourceCfg;
        logic       switchEnableCfgN;
        logic       monitorCfgN;
    } osc_cfg_t;

    typedef struct packed {
        logic newSourceReady;
        logic pllLocked;
        logic newClockTick;
        logic clockFailDetect;
        logic interruptEvent;
    } osc_evt_t;

    typedef struct packed {
        logic        loaded;
        phase_t      phase;
        src_t        cur;
        src_t        nxt;
        logic [1:0]  submode;
        logic        lockSel;
        logic        pllLock;
        logic        fail;
        logic        secEn;
        logic        req;
        logic        recover_on_interrupt;
        logic [2:0]  ratio;
        logic        slowEn;
        logic [2:0]  post;
        logic [5:0]  trim;
        key_t        hiKey;
        key_t        loKey;
        logic [3:0]  settle;
        logic [7:0]  postCnt;
        logic [6:0]  dozeCnt;
        logic        pllOn;
        logic        periphEn;
        logic        cpuEn;
        logic        gateOpen;
        logic [15:0] rdData;
    } osc_state_t;

    localparam osc_state_t STATE_RST = '{
        default:  '0,
        phase:    PH_IDLE,
        cur:      SRC_FAST_RC_DIVIDED,
        nxt:      SRC_FAST_RC_DIVIDED,
        hiKey:    KEY_IDLE,
        loKey:    KEY_IDLE,
        ratio:    RATIO_RST,
        post:     POST_RST,
        gateOpen: 1'b1
    };

endpackage : osc_ctrl_pkg

// ==== src/osc_select_divider.sv ====
// oscillator source selection, switch sequencer and clock dividers
//
// Behaviour
// - current source is a read-only 3-bit field at bits 14-12.
// - requested source is a writable 3-bit field at bits 10-8.
// - both source fields load from the initial-source setting at reset.
// - startup source follows primary submode and initial-source settings.
// - erased or unusable setting starts on fast RC with postscaler, code 111.
// - bit 5 shows PLL lock, zero when unlocked or PLL unused.
// - PLL lock bit forced low at switch start and in non-PLL modes.
// - bit 3 clock-fail flag set by monitor, software can only clear it.
// - with monitor on, bit 7 is set-only and freezes source selection.
// - with monitor off, selections are never locked.
// - bit 1 enables the secondary oscillator, reset low.
// - software sets bit 0 to switch, hardware clears it when done.
// - CPU ratio field at bits 14-12, 1:1 to 1:128, resets to 011.
// - ratio applies only while slowdown enable bit 11 is set.
// - with bit 15 set an interrupt clears slowdown enable.
// - postscaler bits 10-8 divide fast RC by 1..64 or 256, reset 001.
// - same divisors apply to the low-power fast RC source.
// - 6-bit two's-complement trim at bits 5-0, reset zero.
// - unimplemented bits read zero and ignore writes.
// - switch to the already current source clears request, aborts.
// - valid switch waits for source ready, PLL lock if the target uses the PLL, then 10 ticks.
// - changeover copies requested into current and clears request.
// - oscillator register byte writes need key pairs 78h,9Ah high and 46h,57h low.

`timescale 1ns/1ps
`default_nettype none

module osc_select_divider
    import osc_ctrl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire osc_cfg_t    cfg,
    input  wire osc_evt_t    evt,
    input  wire logic [1:0]  regAddr,
    input  wire logic [1:0]  regByteEn,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdData,
    output logic      [2:0]  currentSource,
    output logic      [2:0]  targetSource,
    output logic      [1:0]  primarySubmode,
    output logic             pllEnable,
    output logic             secOscOn,
    output logic      [5:0]  fastRcTrim,
    output logic             periphClkEn,
    output logic             cpuClkEn,
    output logic             sysClkOpen
);

    osc_state_t r;
    osc_state_t n;
    logic       monitorOn;
    logic       switchOn;
    logic       frozen;
    logic       wrOsc;
    logic       wrHi;
    logic       wrLo;
    logic       wrDiv;
    logic       wrTrim;
    logic       busy;
    logic [7:0] postLim;
    logic [6:0] dozeMask;
    logic [2:0] ratioEff;

    function automatic logic usesPll(input src_t s);
        usesPll = (s == SRC_PRIPLL) || (s == SRC_FAST_RC_WITH_PLL);
    endfunction : usesPll

    // checks the startup pair; anything unusable falls back to the default
    function automatic src_t startSrc(input osc_cfg_t c);
        src_t s;
        s = src_t'(c.initialSourceCfg);
        startSrc = SRC_FAST_RC_DIVIDED;
        case (s)
            SRC_PRI, SRC_PRIPLL:
            begin
                if (c.primarySubmodeCfg != SUB_INTERNAL)
                    startSrc = s;
            end
            SRC_SEC:
            begin
                if (c.primarySubmodeCfg == SUB_EC_SEC)
                    startSrc = s;
            end
            default:
            begin
                if (c.primarySubmodeCfg == SUB_INTERNAL)
                    startSrc = s;
            end
        endcase
    endfunction : startSrc

    assign monitorOn = !cfg.switchEnableCfgN && !cfg.monitorCfgN;
    assign switchOn  = !cfg.switchEnableCfgN;
    // lock only bites with the monitor strapped on
    assign frozen    = monitorOn && r.lockSel;
    assign wrOsc     = regWrite && (regAddr == ADDR_OSC);
    assign wrHi      = wrOsc && regByteEn[HI_LANE];
    assign wrLo      = wrOsc && regByteEn[LO_LANE];
    assign wrDiv     = regWrite && (regAddr == ADDR_DIV);
    assign wrTrim    = regWrite && (regAddr == ADDR_TRIM);
    // target is held while a switch runs, so the copy is what was checked
    assign busy      = (r.phase != PH_IDLE);

    // postscaler only acts on the two divided fast RC sources
    always_comb
    begin
        postLim = '0;
        case (r.cur)
            SRC_FAST_RC_DIVIDED, SRC_LPFRCD:
            begin
                if (r.post == POST_MAX)
                    postLim = LIM_MAX;
                else
                    postLim = 8'((9'h001 << r.post) - 9'h001);
            end
            default:
            begin
                postLim = '0;
            end
        endcase
        // a cleared slowdown enable runs the cpu at the peripheral rate
        ratioEff = '0;
        if (r.slowEn)
            ratioEff = r.ratio;
        dozeMask = 7'((8'h01 << ratioEff) - 8'h01);
    end

    always_comb
    begin
        logic [15:0] rd;
        rd = '0;
        n  = r;

        // unlock keys: any write that breaks a pair disarms it
        // keys are kept per lane; reads leave them armed
        if (regWrite)
        begin
            n.hiKey = KEY_IDLE;
            n.loKey = KEY_IDLE;
            if (wrHi && r.hiKey == KEY_FIRST
                && regWrData[HI_LSB+:8] == KEY_HI2)
                n.hiKey = KEY_ARMED;
            else if (wrHi && regWrData[HI_LSB+:8] == KEY_HI1)
                n.hiKey = KEY_FIRST;
            if (wrLo && r.loKey == KEY_FIRST
                && regWrData[LO_LSB+:8] == KEY_LO2)
                n.loKey = KEY_ARMED;
            else if (wrLo && regWrData[LO_LSB+:8] == KEY_LO1)
                n.loKey = KEY_FIRST;
        end

        // source and submode straps are sampled once, on the first edge after reset release
        if (!r.loaded)
        begin
            n.loaded  = 1'b1;
            n.cur     = startSrc(cfg);
            n.nxt     = startSrc(cfg);
            n.submode = cfg.primarySubmodeCfg;
        end

        if (wrHi && r.hiKey == KEY_ARMED && !frozen && !busy)
            n.nxt = src_t'(regWrData[NEXT_LSB+:3]);

        if (wrLo && r.loKey == KEY_ARMED)
        begin
            if (regWrData[LOCKSEL_BIT] && monitorOn)
                n.lockSel = 1'b1;
            if (!regWrData[FAIL_BIT])
                n.fail = 1'b0;
            n.secEn = regWrData[SEC_BIT];
            if (regWrData[REQ_BIT] && switchOn && !frozen)
                n.req = 1'b1;
        end

        if (wrDiv && regByteEn[HI_LANE])
        begin
            n.recover_on_interrupt    = regWrData[ROI_BIT];
            n.ratio  = regWrData[RATIO_LSB+:3];
            n.slowEn = regWrData[SLOW_BIT];
            n.post   = regWrData[POST_LSB+:3];
        end

        if (wrTrim && regByteEn[LO_LANE])
            n.trim = regWrData[TRIM_LSB+:6];

        // the documented auto-clear beats a software set in the same cycle
        if (evt.interruptEvent && r.recover_on_interrupt)
            n.slowEn = 1'b0;

        // lock status tracks whichever source the PLL is serving
        if (r.phase == PH_IDLE)
            n.pllLock = usesPll(r.cur) && evt.pllLocked;
        else
            n.pllLock = usesPll(r.nxt) && evt.pllLocked;

        case (r.phase)
            PH_IDLE:
            begin
                if (r.req)
                    n.phase = PH_CHECK;
            end
            PH_CHECK:
            begin
                if (r.nxt == r.cur)
                begin
                    n.req   = 1'b0;
                    n.phase = PH_IDLE;
                end
                else
                begin
                    // a valid switch starts by dropping lock and fail status
                    n.pllLock = 1'b0;
                    n.fail    = 1'b0;
                    n.phase   = PH_WAIT;
                end
            end
            PH_WAIT:
            begin
                // a source that never comes up leaves the request standing
                if (evt.newSourceReady
                    && (!usesPll(r.nxt) || evt.pllLocked))
                begin
                    n.settle = '0;
                    n.phase  = PH_SETTLE;
                end
            end
            PH_SETTLE:
            begin
                // ticks are edges of the new clock, not of ref_clk
                if (evt.newClockTick)
                begin
                    n.settle = r.settle + 4'h1;
                    if (r.settle == SETTLE_TICKS - 4'h1)
                        n.phase = PH_CHANGE;
                end
            end
            PH_CHANGE:
            begin
                // the held target is copied, so no late write can race it
                n.cur   = r.nxt;
                n.req   = 1'b0;
                n.phase = PH_IDLE;
            end
            default:
            begin
                n.phase = PH_IDLE;
            end
        endcase

        // a fail event wins over any clear in the same cycle
        if (evt.clockFailDetect && monitorOn)
            n.fail = 1'b1;

        // switching strapped off: the request bit never stands
        if (!switchOn)
            n.req = 1'b0;
        if (!monitorOn)
            n.lockSel = 1'b0;

        // the PLL runs for the target too while a switch is in flight
        n.pllOn = usesPll(r.cur)
                  || (r.phase != PH_IDLE && usesPll(r.nxt));

        // enables stay low for the changeover so no short phase leaks out
        n.gateOpen = (r.phase != PH_CHANGE);
        n.periphEn = 1'b0;
        n.cpuEn    = 1'b0;
        if (r.gateOpen)
        begin
            if (r.postCnt >= postLim)
            begin
                n.postCnt  = '0;
                n.periphEn = 1'b1;
                // cpu pulse rides on a peripheral pulse, so peripheral
                // timing is untouched by ratio changes
                n.cpuEn   = ((r.dozeCnt & dozeMask) == '0);
                n.dozeCnt = (r.dozeCnt + 7'h01) & dozeMask;
            end
            else
            begin
                n.postCnt = r.postCnt + 8'h01;
            end
        end

        if (regRead)
        begin
            case (regAddr)
                ADDR_OSC:
                begin
                    rd[CUR_LSB+:3]   = r.cur;
                    rd[NEXT_LSB+:3]  = r.nxt;
                    rd[LOCKSEL_BIT]  = r.lockSel;
                    rd[PLLLOCK_BIT]  = r.pllLock;
                    rd[FAIL_BIT]     = r.fail;
                    rd[SEC_BIT]      = r.secEn;
                    rd[REQ_BIT]      = r.req;
                end
                ADDR_DIV:
                begin
                    rd[ROI_BIT]       = r.recover_on_interrupt;
                    rd[RATIO_LSB+:3]  = r.ratio;
                    rd[SLOW_BIT]      = r.slowEn;
                    rd[POST_LSB+:3]   = r.post;
                end
                ADDR_TRIM:
                begin
                    rd[TRIM_LSB+:6] = r.trim;
                end
                default:
                begin
                    rd = '0;
                end
            endcase
        end
        n.rdData = rd;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            r <= STATE_RST;
        else
            r <= n;
    end

    assign regRdData      = r.rdData;
    assign currentSource  = r.cur;
    assign targetSource   = r.nxt;
    assign primarySubmode = r.submode;
    assign pllEnable      = r.pllOn;
    assign secOscOn       = r.secEn;
    assign fastRcTrim     = r.trim;
    assign periphClkEn    = r.periphEn;
    assign cpuClkEn       = r.cpuEn;
    assign sysClkOpen     = r.gateOpen;

endmodule : osc_select_divider

`default_nettype wire
